// >>> odct_decoder.sv
// Instruction decoder assigning an execution clock count to each recognised form
module odct_decoder (
    input wire logic sys_clk_in,
    input wire logic srst_in,
    input wire logic byte_valid_in,
    input wire logic [7:0] byte_in,
    output logic byte_ready_out,
    output logic done_out,
    output odct_pkg::odct_op_e op_out,
    output logic [odct_pkg::CLK_W-1:0] clocks_out,
    output logic mem_operand_out,
    output logic dir_out,
    output logic word_out,
    output logic [2:0] reg_field_out,
    output logic [15:0] frame_size_out,
    output logic [7:0] frame_level_out
);
    import odct_pkg::*;

    typedef struct packed {
        odct_state_e state;
        odct_op_e pend;
        logic dir;
        logic word;
        logic [15:0] size;
        logic done;
        odct_op_e op;
        logic [CLK_W-1:0] clocks;
        logic mem;
        logic [2:0] reg_field;
        logic [7:0] level;
        logic ready;
    } odct_state_s;

    odct_state_s cur;
    odct_state_s next_cur;
    logic [CLK_W-1:0] build_clocks;

    odct_frame_clocks u_frame (
        .level_in(byte_in),
        .clocks_out(build_clocks)
    );

    always_comb begin
        logic is_mem;
        is_mem = byte_in[MOD_HI:MOD_LO] != MOD_REGISTER;
        next_cur = cur;
        next_cur.done = 1'b0;
        // Ready is low until the first clock after reset, then always high; no internal buffering
        next_cur.ready = 1'b1;
        if (byte_valid_in) begin
            unique case (cur.state)
                ODCT_IDLE: begin
                    next_cur.dir = byte_in[DIR_BIT];
                    next_cur.word = byte_in[WIDTH_BIT];
                    next_cur.state = ODCT_OPERAND;
                    next_cur.mem = 1'b0;
                    next_cur.size = 16'h0000;
                    next_cur.level = 8'h00;
                    next_cur.reg_field = 3'h0;
                    if (byte_in == OP_SEG_LOAD) begin
                        next_cur.pend = ODCT_SEG_LOAD;
                    end else if (byte_in == OP_SEG_STORE) begin
                        next_cur.pend = ODCT_SEG_STORE;
                    end else if ((byte_in & OP_ADD_MASK) == OP_ADD) begin
                        next_cur.pend = ODCT_ADD;
                    end else if (byte_in == OP_FAR_PTR_DATA_SEG) begin
                        next_cur.pend = ODCT_FAR_PTR_DATA_SEG;
                    end else if (byte_in == OP_FAR_PTR_EXTRA_SEG) begin
                        next_cur.pend = ODCT_FAR_PTR_EXTRA_SEG;
                    end else if (byte_in == OP_FRAME_BUILD) begin
                        next_cur.pend = ODCT_FRAME_BUILD;
                        next_cur.state = ODCT_SIZE_LO;
                    end else begin
                        next_cur.state = ODCT_IDLE;
                        next_cur.done = 1'b1;
                        next_cur.dir = 1'b0;
                        next_cur.word = 1'b0;
                        // Single-byte forms finish on their own byte
                        if (byte_in == OP_FRAME_TEARDOWN) begin
                            next_cur.op = ODCT_FRAME_TEARDOWN;
                            next_cur.clocks = CLK_TEARDOWN;
                        end else if (byte_in == OP_FLAGS_TO_ACC_HIGH) begin
                            next_cur.op = ODCT_FLAGS_TO_ACC_HIGH;
                            next_cur.clocks = CLK_FLAG_XFER;
                        end else if (byte_in == OP_ACC_HIGH_TO_FLAGS) begin
                            next_cur.op = ODCT_ACC_HIGH_TO_FLAGS;
                            next_cur.clocks = CLK_FLAG_XFER;
                        end else if (byte_in == OP_TABLE_TRANSLATE) begin
                            next_cur.op = ODCT_TABLE_TRANSLATE;
                            next_cur.clocks = CLK_TRANSLATE;
                        end else begin
                            // Forms outside this decoder report zero clocks
                            next_cur.op = ODCT_UNKNOWN;
                            next_cur.clocks = '0;
                        end
                    end
                end
                ODCT_OPERAND: begin
                    next_cur.state = ODCT_IDLE;
                    next_cur.done = 1'b1;
                    next_cur.op = cur.pend;
                    next_cur.mem = is_mem;
                    next_cur.reg_field = byte_in[5:3];
                    unique case (cur.pend)
                        ODCT_SEG_LOAD: next_cur.clocks = is_mem ? CLK_SEG_LOAD_MEM : CLK_SEG_LOAD_REG;
                        ODCT_SEG_STORE: next_cur.clocks = is_mem ? CLK_SEG_STORE_MEM : CLK_SEG_STORE_REG;
                        ODCT_ADD: next_cur.clocks = is_mem ? CLK_ADD_MEM : CLK_ADD_REG;
                        // Register operand is not a legal pointer source; count is kept anyway
                        default: next_cur.clocks = CLK_FAR_PTR;
                    endcase
                end
                ODCT_SIZE_LO: begin
                    next_cur.size[7:0] = byte_in;
                    next_cur.state = ODCT_SIZE_HI;
                end
                ODCT_SIZE_HI: begin
                    next_cur.size[15:8] = byte_in;
                    next_cur.state = ODCT_LEVEL;
                end
                ODCT_LEVEL: begin
                    next_cur.state = ODCT_IDLE;
                    next_cur.done = 1'b1;
                    next_cur.op = ODCT_FRAME_BUILD;
                    next_cur.level = byte_in;
                    next_cur.clocks = build_clocks;
                end
                default: next_cur.state = ODCT_IDLE;
            endcase
        end
    end

    always_ff @(posedge sys_clk_in) begin
        if (srst_in) begin
            cur <= '{state: ODCT_IDLE, pend: ODCT_NONE, op: ODCT_NONE, default: '0};
        end else begin
            cur <= next_cur;
        end
    end

    assign byte_ready_out = cur.ready;
    assign done_out = cur.done;
    assign op_out = cur.op;
    assign clocks_out = cur.clocks;
    assign mem_operand_out = cur.mem;
    assign dir_out = cur.dir;
    assign word_out = cur.word;
    assign reg_field_out = cur.reg_field;
    assign frame_size_out = cur.size;
    assign frame_level_out = cur.level;
endmodule

// >>> odct_decoder_sva.sv
// Assertions on the decoder's clock counts
module odct_decoder_sva (
    input wire logic sys_clk_in,
    input wire logic srst_in,
    input wire logic byte_valid_in,
    input wire logic [7:0] byte_in,
    input wire logic done_out,
    input odct_pkg::odct_op_e op_out,
    input wire logic [11:0] clocks_out,
    input wire logic mem_operand_out,
    input wire logic [7:0] frame_level_out
);
    import odct_pkg::*;
    default clocking @(posedge sys_clk_in); endclocking
    default disable iff (srst_in);
    property p_clk(odct_op_e o, logic [11:0] c);
        done_out && op_out == o |-> clocks_out == c;
    endproperty
    AST_SEG_LOAD: assert property (p_clk(ODCT_SEG_LOAD, mem_operand_out ? 12'h008 : 12'h003))
        else $error("seg load clocks");
    AST_SEG_STORE: assert property (p_clk(ODCT_SEG_STORE, 12'h002)) else $error("seg store clocks");
    AST_ADD: assert property (p_clk(ODCT_ADD, mem_operand_out ? 12'h007 : 12'h001)) else $error("add clocks");
    AST_BUILD: assert property (p_clk(ODCT_FRAME_BUILD, (frame_level_out == 8'h00) ? 12'h007 :
        12'h00B + 12'h00A * ({4'h0, frame_level_out} - 12'h001))) else $error("build clocks");
    AST_TEARDOWN: assert property (done_out && op_out == ODCT_FRAME_TEARDOWN |->
        clocks_out == 12'h007 && $past(byte_valid_in && byte_in == 8'hC9)) else $error("teardown");
    AST_FLAGS_OUT: assert property (p_clk(ODCT_FLAGS_TO_ACC_HIGH, 12'h002)) else $error("flags out");
    AST_FLAGS_IN: assert property (p_clk(ODCT_ACC_HIGH_TO_FLAGS, 12'h002)) else $error("flags in");
    AST_TRANSLATE: assert property (p_clk(ODCT_TABLE_TRANSLATE, 12'h00A)) else $error("translate");
    AST_FAR_DS: assert property (p_clk(ODCT_FAR_PTR_DATA_SEG, 12'h00E)) else $error("far data");
    AST_FAR_ES: assert property (p_clk(ODCT_FAR_PTR_EXTRA_SEG, 12'h00E)) else $error("far extra");
    cover property (done_out && op_out == ODCT_FRAME_BUILD && frame_level_out > 8'h01);
    cover property (done_out && op_out == ODCT_SEG_LOAD && mem_operand_out);
    cover property (done_out ##1 done_out);
endmodule
bind odct_decoder odct_decoder_sva i_sva (.sys_clk_in, .srst_in, .byte_valid_in, .byte_in, .done_out,
    .op_out, .clocks_out, .mem_operand_out, .frame_level_out);

// >>> odct_frame_clocks.sv
// Clock count of the stack-frame build for a nesting level
module odct_frame_clocks (
    input wire logic [7:0] level_in,
    output logic [odct_pkg::CLK_W-1:0] clocks_out
);
    import odct_pkg::*;
    always_comb begin
        if (level_in == 8'h00) begin
            clocks_out = CLK_BUILD_L0;
        end else begin
            // 11 + 10 * (L - 1); 255 levels at most fits 12 bits
            clocks_out = CLK_BUILD_BASE + CLK_W'(CLK_BUILD_STEP * CLK_W'(level_in - 8'h01));
        end
    end
endmodule

// >>> odct_pkg.sv
// Opcode patterns, operand fields and clock counts for the decoder
package odct_pkg;
    localparam logic [7:0] OP_SEG_LOAD = 8'h8E;
    localparam logic [7:0] OP_SEG_STORE = 8'h8C;
    localparam logic [7:0] OP_ADD_MASK = 8'hFC;
    localparam logic [7:0] OP_ADD = 8'h00;
    localparam logic [7:0] OP_FRAME_BUILD = 8'hC8;
    localparam logic [7:0] OP_FRAME_TEARDOWN = 8'hC9;
    localparam logic [7:0] OP_FLAGS_TO_ACC_HIGH = 8'h9F;
    localparam logic [7:0] OP_ACC_HIGH_TO_FLAGS = 8'h9E;
    localparam logic [7:0] OP_TABLE_TRANSLATE = 8'hD7;
    localparam logic [7:0] OP_FAR_PTR_DATA_SEG = 8'hC5;
    localparam logic [7:0] OP_FAR_PTR_EXTRA_SEG = 8'hC4;
    localparam logic [1:0] MOD_REGISTER = 2'h3;
    localparam int MOD_HI = 7;
    localparam int MOD_LO = 6;
    localparam int DIR_BIT = 1;
    localparam int WIDTH_BIT = 0;
    localparam int CLK_W = 12;
    localparam logic [11:0] CLK_SEG_LOAD_REG = 12'h003;
    localparam logic [11:0] CLK_SEG_LOAD_MEM = 12'h008;
    localparam logic [11:0] CLK_SEG_STORE_REG = 12'h002;
    localparam logic [11:0] CLK_SEG_STORE_MEM = 12'h002;
    localparam logic [11:0] CLK_ADD_REG = 12'h001;
    localparam logic [11:0] CLK_ADD_MEM = 12'h007;
    localparam logic [11:0] CLK_BUILD_L0 = 12'h007;
    localparam logic [11:0] CLK_BUILD_BASE = 12'h00B;
    localparam logic [11:0] CLK_BUILD_STEP = 12'h00A;
    localparam logic [11:0] CLK_TEARDOWN = 12'h007;
    localparam logic [11:0] CLK_FLAG_XFER = 12'h002;
    localparam logic [11:0] CLK_TRANSLATE = 12'h00A;
    localparam logic [11:0] CLK_FAR_PTR = 12'h00E;
    typedef enum logic [3:0] {
        ODCT_NONE = 4'h0,
        ODCT_SEG_LOAD = 4'h1,
        ODCT_SEG_STORE = 4'h2,
        ODCT_ADD = 4'h3,
        ODCT_FRAME_BUILD = 4'h4,
        ODCT_FRAME_TEARDOWN = 4'h5,
        ODCT_FLAGS_TO_ACC_HIGH = 4'h6,
        ODCT_ACC_HIGH_TO_FLAGS = 4'h7,
        ODCT_TABLE_TRANSLATE = 4'h8,
        ODCT_FAR_PTR_DATA_SEG = 4'h9,
        ODCT_FAR_PTR_EXTRA_SEG = 4'hA,
        ODCT_UNKNOWN = 4'hF
    } odct_op_e;
    typedef enum logic [2:0] {
        ODCT_IDLE = 3'b000,
        ODCT_OPERAND = 3'b100,
        ODCT_SIZE_LO = 3'b001,
        ODCT_SIZE_HI = 3'b011,
        ODCT_LEVEL = 3'b010
    } odct_state_e;
endpackage

// >>> odct_prefetch_model.sv
// Prefetch queue model feeding instruction bytes to the decoder
module odct_prefetch_model (
    input wire logic sys_clk_in,
    input wire logic slow_in,
    output logic byte_valid_out,
    output logic [7:0] byte_out
);
    logic [7:0] q[$];
    logic gap = 1'b0;
    initial begin
        byte_valid_out = 1'b0;
        byte_out = 8'h00;
    end
    always @(negedge sys_clk_in) begin
        gap = slow_in && !gap;
        if (q.size() > 0 && !gap) begin
            byte_valid_out = 1'b1;
            byte_out = q.pop_front();
        end else begin
            byte_valid_out = 1'b0;
            // Idle byte toggles so a stale opcode never looks valid
            byte_out = ~byte_out;
        end
    end
endmodule

// >>> opcode_decode_cycle_timing_bench.sv
// Self-checking bench for the opcode decoder
`define CHK(a, e) begin samples_checked++; if ((a) !== (e)) begin miscompares++; \
    $display("ERROR %0t got %h expected %h", $time, a, e); end end
module opcode_decode_cycle_timing_bench;
    timeunit 1ns;
    timeprecision 1ps;
    import odct_pkg::*;
    logic sys_clk_in = 1'b0, srst_in = 1'b1, slow = 1'b0;
    logic valid, done, mem, dir, word, ready;
    logic [2:0] regf;
    logic [7:0] data, flev;
    logic [11:0] clk_cnt;
    logic [15:0] fsize;
    odct_op_e op;
    int miscompares = 0, samples_checked = 0, cycles = 0;
    // Rows: byte count, bytes, op, memory flag, clocks
    logic [55:0] rows [17] = '{56'h2_8EC00000_1_0_003, 56'h2_8E060000_1_1_008, 56'h2_8CC80000_2_0_002,
        56'h2_8C460000_2_1_002, 56'h2_00C10000_3_0_001, 56'h2_03070000_3_1_007, 56'h4_C8341200_4_0_007,
        56'h4_C8000001_4_0_00B, 56'h4_C8000003_4_0_01F, 56'h4_C80000FF_4_0_9F7, 56'h1_C9000000_5_0_007,
        56'h1_9F000000_6_0_002, 56'h1_9E000000_7_0_002, 56'h1_D7000000_8_0_00A, 56'h2_C5060000_9_1_00E,
        56'h2_C4C00000_A_0_00E, 56'h1_F4000000_F_0_000};
    odct_prefetch_model i_pf (.sys_clk_in, .slow_in(slow), .byte_valid_out(valid), .byte_out(data));
    odct_decoder i_dut (.sys_clk_in, .srst_in, .byte_valid_in(valid), .byte_in(data), .byte_ready_out(ready),
        .done_out(done), .op_out(op), .clocks_out(clk_cnt), .mem_operand_out(mem), .dir_out(dir),
        .word_out(word), .reg_field_out(regf), .frame_size_out(fsize), .frame_level_out(flev));
    initial forever #5 sys_clk_in = ~sys_clk_in;
    task automatic stop_test();
        $display("checked %0d mismatches %0d", samples_checked, miscompares);
        if (miscompares == 0 && samples_checked > 0) $display("TEST PASSED");
        else $display("TEST FAILED");
        $finish;
    endtask
    task automatic wait_done();
        int n = 0;
        do begin
            @(negedge sys_clk_in);
            n++;
        end while (done !== 1'b1 && n < 60);
        `CHK(done, 1'b1)
    endtask
    task automatic send(input logic [31:0] b, input int cnt);
        for (int k = 0; k < cnt; k++) i_pf.q.push_back(b[31-8*k -: 8]);
    endtask
    always @(posedge sys_clk_in) begin
        cycles++;
        if (cycles == 2000) begin
            miscompares++;
            stop_test();
        end
    end
    initial begin
        repeat (10) @(negedge sys_clk_in);
        srst_in = 1'b0;
        // Second pass stalls the byte stream every other cycle
        for (int p = 0; p < 2; p++) begin
            slow = p[0];
            foreach (rows[i]) begin
                send(rows[i][51:20], int'(rows[i][55:52]));
                wait_done();
                `CHK(op, odct_op_e'(rows[i][19:16]))
                `CHK(mem, rows[i][12])
                `CHK(clk_cnt, rows[i][11:0])
            end
        end
        // Stalls off, so paired single-byte forms finish on adjacent cycles
        slow = 1'b0;
        send(32'hC8341202, 4);
        wait_done();
        `CHK({fsize, flev, clk_cnt}, {16'h1234, 8'h02, 12'h015})
        send(32'h03D90000, 2);
        wait_done();
        `CHK({dir, word, mem, regf, clk_cnt}, {3'b110, 3'h3, 12'h001})
        send(32'hC9D70000, 2);
        wait_done();
        `CHK(op, ODCT_FRAME_TEARDOWN)
        @(negedge sys_clk_in);
        `CHK({done, op, clk_cnt}, {1'b1, ODCT_TABLE_TRANSLATE, 12'h00A})
        send(32'h8E000000, 1);
        repeat (2) @(negedge sys_clk_in);
        srst_in = 1'b1;
        @(negedge sys_clk_in);
        srst_in = 1'b0;
        `CHK({ready, op, clk_cnt}, {1'b0, ODCT_NONE, 12'h000})
        send(32'h8EC00000, 2);
        wait_done();
        `CHK({ready, op, clk_cnt}, {1'b1, ODCT_SEG_LOAD, 12'h003})
        stop_test();
    end
endmodule
